// File: rtl/fcs_pkg.sv
package fcs_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int ON_TIME_LIMIT_NS = 50000;  // Nominal on-phase limit, 50 us
   localparam int OFF_TIME_LIMIT_NS = 25000; // Nominal off-phase limit, 25 us
   localparam int TMR_W = 12;
   localparam logic [TMR_W-1:0] ON_LIMIT_CYC = TMR_W'(ON_TIME_LIMIT_NS / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] OFF_LIMIT_CYC = TMR_W'(OFF_TIME_LIMIT_NS / CLK_PERIOD_NS);
   localparam int SHORT_LIMIT_DEF = 65536;   // Off-limit expiries to sense-short fault; the first 65535 force the switch on
   localparam int CNT_W = 17;

   // ****************************************************************
   // Register map and fields
   // ****************************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_COUNT = 8'h08;
   localparam int CTRL_ALLOW_BIT = 0;
   localparam logic CTRL_ALLOW_RST = 1'b1;
   localparam int ST_SWITCH_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_SHORT_BIT = 2;
   localparam int ST_MAXON_BIT = 3;
   localparam int ST_UNDERVOLTAGE_LOCKOUT_BIT = 4;
   localparam int ST_TSD_BIT = 5;
   localparam int ST_START_BIT = 6;
   localparam int ST_SUSP_BIT = 7;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ON,
      ST_OFF,
      ST_SUSP,
      ST_DONE
   } fcs_state_e;

   // Pin-level inputs, all asynchronous to clk
   typedef struct packed {
      logic start;                // Host charge start
      logic full;                 // feedback_sense reached full level
      logic off_det;              // feedback_sense at/below off level
      logic peak;                 // Primary current reached peak_current_set
      logic undervoltage_lockout; // Supply below lockout level
      logic thermal_shutdown;     // Die over temperature
      logic flash_trigger_in;     // Flash trigger request
   } fcs_pins_s;

   localparam int PINS_W = $bits(fcs_pins_s);

endpackage

// File: rtl/fcs_sync.sv
`timescale 1ns/1ps
`default_nettype none

module fcs_sync
   import fcs_pkg::*;
#(
   parameter int W = 1
)
(
   input wire logic clk,            // System clock
   input wire logic srst,           // Synchronous reset
   input wire logic [W-1:0] d,      // Asynchronous inputs
   output logic [W-1:0] q           // Synchronised outputs
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // Two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_ff <= '0;
         q_ff <= '0;
      end
      else
      begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;

endmodule // fcs_sync
`default_nettype wire

// File: rtl/fcs_charge_seq.sv
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - switch stays off until off-detect or limit
// - off-detect turns switch on at once
// - full level: charge-done low, switching stops
// - lockout suspends charging, switch off, no latch
// - lockout release resumes charging automatically
// - lockout forces flash gate output low
// - over-temperature suspends, resumes when cleared
// - 65535 forced-on cycles, then next off-limit expiry declares sense-short fault
// - faults clear only on start rise, unlocked
// - off-time limit expiry forces switch on
// - on-time limit expiry is fault, stops
// - start high charges, start low stops
// - start low returns charge-done high
// - on-time limit nominally 50 us
// - off-time limit nominally 25 us
module fcs_charge_seq
   import fcs_pkg::*;
#(
   parameter int SHORT_LIMIT = SHORT_LIMIT_DEF
)
(
   input wire logic clk,               // 50 MHz clock
   input wire logic srst,              // Synchronous reset, active high
   input wire fcs_pins_s pins,         // Asynchronous pin inputs
   output logic power_switch_gate,     // Power switch gate drive
   output logic charge_done_n,         // Charge done, active low
   output logic flash_gate_out,        // Flash gate drive
   input wire logic wb_cyc_i,          // Wishbone cycle
   input wire logic wb_stb_i,          // Wishbone strobe
   input wire logic wb_we_i,           // Wishbone write enable
   input wire logic [7:0] wb_adr_i,    // Wishbone byte address
   input wire logic [31:0] wb_dat_i,   // Wishbone write data
   input wire logic [3:0] wb_sel_i,    // Wishbone byte selects
   output logic [31:0] wb_dat_o,       // Wishbone read data
   output logic wb_ack_o               // Wishbone acknowledge
);

   localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(SHORT_LIMIT - 1);

   // ****************************************************************
   // Input synchronisation
   // ****************************************************************
   fcs_pins_s s_pin;
   logic [PINS_W-1:0] s_pin_vec;

   fcs_sync #(.W(PINS_W)) u_sync (
      .clk(clk),
      .srst(srst),
      .d(pins),
      .q(s_pin_vec)
   );

   assign s_pin = fcs_pins_s'(s_pin_vec);

   // ****************************************************************
   // Charge sequencer
   // ****************************************************************
   fcs_state_e state_ff, nxt_state;
   logic [TMR_W-1:0] tmr_ff, nxt_tmr;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic short_ff, nxt_short;
   logic maxon_ff, nxt_maxon;
   logic start_q_ff, nxt_start_q;
   logic gate_ff, nxt_gate;
   logic done_n_ff, nxt_done_n;
   logic flash_ff, nxt_flash;
   logic allow_ff, nxt_allow;
   logic start_rise;
   logic run;
   logic hold;
   logic on_expired;
   logic off_expired;

   assign start_rise = s_pin.start & ~start_q_ff;
   assign run = s_pin.start & allow_ff;
   assign hold = s_pin.undervoltage_lockout | s_pin.thermal_shutdown;
   assign on_expired = (tmr_ff >= ON_LIMIT_CYC);
   assign off_expired = (tmr_ff >= OFF_LIMIT_CYC);

   // Next state of the sequencer
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_short = short_ff;
      nxt_maxon = maxon_ff;
      nxt_start_q = s_pin.start;
      nxt_tmr = (tmr_ff == '1) ? tmr_ff : tmr_ff + 1'b1;
      // Restart edge with lockout released clears latched faults
      if (start_rise && !s_pin.undervoltage_lockout)
      begin
         nxt_short = 1'b0;
         nxt_maxon = 1'b0;
      end
      if (!run)
      begin
         nxt_state = ST_IDLE;
         nxt_cnt = '0;
      end
      else
      begin
         case (state_ff)
            ST_IDLE:
            begin
               nxt_cnt = '0;
               if (!nxt_short && !nxt_maxon)
                  nxt_state = hold ? ST_SUSP : ST_ON;
            end
            ST_ON:
            begin
               if (hold)
                  nxt_state = ST_SUSP;
               else if (s_pin.full)
                  nxt_state = ST_DONE;
               else if (s_pin.peak)
                  nxt_state = ST_OFF;
               else if (on_expired)
               begin
                  nxt_maxon = 1'b1;
                  nxt_state = ST_IDLE;
                  nxt_cnt = '0;
               end
            end
            ST_OFF:
            begin
               if (hold)
                  nxt_state = ST_SUSP;
               else if (s_pin.full)
                  nxt_state = ST_DONE;
               else if (s_pin.off_det)
               begin
                  nxt_state = ST_ON;
                  nxt_cnt = '0;
               end
               else if (off_expired)
               begin
                  if (cnt_ff == SHORT_LAST)
                  begin
                     nxt_short = 1'b1;
                     nxt_state = ST_IDLE;
                     nxt_cnt = '0;
                  end
                  else
                  begin
                     nxt_state = ST_ON;
                     nxt_cnt = cnt_ff + 1'b1;
                  end
               end
            end
            ST_SUSP:
               if (!hold)
                  nxt_state = ST_ON;
            ST_DONE:
               nxt_state = ST_DONE;  // Leaves only when start falls or the allow bit is cleared
            default:
               nxt_state = ST_IDLE;
         endcase
      end
      if (nxt_state != state_ff)
         nxt_tmr = '0;
   end

   // Output next values; gate and done from the next state, flash from the pins
   always_comb
   begin
      nxt_gate = (nxt_state == ST_ON);
      nxt_done_n = (nxt_state != ST_DONE);
      nxt_flash = s_pin.flash_trigger_in & ~s_pin.undervoltage_lockout;
   end

   // Sequencer and output registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_ff <= ST_IDLE;
         tmr_ff <= '0;
         cnt_ff <= '0;
         short_ff <= 1'b0;
         maxon_ff <= 1'b0;
         start_q_ff <= 1'b0;
         gate_ff <= 1'b0;
         done_n_ff <= 1'b1;
         flash_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         tmr_ff <= nxt_tmr;
         cnt_ff <= nxt_cnt;
         short_ff <= nxt_short;
         maxon_ff <= nxt_maxon;
         start_q_ff <= nxt_start_q;
         gate_ff <= nxt_gate;
         done_n_ff <= nxt_done_n;
         flash_ff <= nxt_flash;
      end
   end

   assign power_switch_gate = gate_ff;
   assign charge_done_n = done_n_ff;
   assign flash_gate_out = flash_ff;

   // ****************************************************************
   // Wishbone register slave
   // ****************************************************************
   logic ack_ff, nxt_ack;
   logic [31:0] rdata_ff, nxt_rdata;
   logic req;
   logic [31:0] status_word;

   assign req = wb_cyc_i & wb_stb_i & ~ack_ff;

   // Status word gathered from sequencer state
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[ST_SWITCH_BIT] = gate_ff;
      status_word[ST_DONE_BIT] = ~done_n_ff;
      status_word[ST_SHORT_BIT] = short_ff;
      status_word[ST_MAXON_BIT] = maxon_ff;
      status_word[ST_UNDERVOLTAGE_LOCKOUT_BIT] = s_pin.undervoltage_lockout;
      status_word[ST_TSD_BIT] = s_pin.thermal_shutdown;
      status_word[ST_START_BIT] = s_pin.start;
      status_word[ST_SUSP_BIT] = (state_ff == ST_SUSP);
   end

   // Decode, write and read data
   always_comb
   begin
      nxt_ack = req;
      nxt_allow = allow_ff;
      nxt_rdata = 32'h0000_0000;
      // Write lands at the edge where the master sees ack
      if (wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL)
         nxt_allow = wb_dat_i[CTRL_ALLOW_BIT];
      if (req)
      begin
         case (wb_adr_i)
            REG_CTRL:
               nxt_rdata[CTRL_ALLOW_BIT] = allow_ff;
            REG_STATUS:
               nxt_rdata = status_word;
            REG_COUNT:
               nxt_rdata[CNT_W-1:0] = cnt_ff;
            default:
               nxt_rdata = 32'h0000_0000;  // Unmapped reads zero
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         allow_ff <= CTRL_ALLOW_RST;
      end
      else
      begin
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
         allow_ff <= nxt_allow;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   a_undervoltage_lockout_gate_off: assert property (
      s_pin.undervoltage_lockout |=> !power_switch_gate)
      else $error("switch on during lockout");
   a_undervoltage_lockout_flash_low: assert property (
      s_pin.undervoltage_lockout |=> !flash_gate_out)
      else $error("flash gate high during lockout");
   a_offdet_turn_on: assert property (
      run && !hold && state_ff == ST_OFF && !s_pin.full && s_pin.off_det
      |=> power_switch_gate && cnt_ff == '0)
      else $error("off-detect did not turn switch on");
   a_full_done_low: assert property (
      run && !hold && state_ff inside {ST_ON, ST_OFF} && s_pin.full
      |=> !charge_done_n && !power_switch_gate)
      else $error("full level not reported");
   a_off_limit_on: assert property (
      run && !hold && state_ff == ST_OFF && !s_pin.full && !s_pin.off_det
      && tmr_ff == OFF_LIMIT_CYC && cnt_ff != SHORT_LAST
      |=> power_switch_gate && cnt_ff == $past(cnt_ff) + 1'b1)
      else $error("off limit did not force switch on");
   a_short_fault_set: assert property (
      run && !hold && state_ff == ST_OFF && !s_pin.full && !s_pin.off_det
      && off_expired && cnt_ff == SHORT_LAST
      |=> short_ff && !power_switch_gate)
      else $error("sense-short fault not declared");
   a_on_limit_fault: assert property (
      run && !hold && state_ff == ST_ON && !s_pin.full && !s_pin.peak
      && tmr_ff == ON_LIMIT_CYC
      |=> maxon_ff && !power_switch_gate ##1 !power_switch_gate)
      else $error("on limit fault not taken");

   a_peak_ends_on: assert property (
      run && !hold && state_ff == ST_ON && !s_pin.full && s_pin.peak
      |=> !power_switch_gate && state_ff == ST_OFF)
      else $error("peak current did not end on-phase");

   a_start_low_stop: assert property (
      !s_pin.start |=> !power_switch_gate && charge_done_n)
      else $error("start low did not stop charging");

   a_fault_clear_edge: assert property (
      $fell(short_ff) || $fell(maxon_ff)
      |-> $past(start_rise) && !$past(s_pin.undervoltage_lockout))
      else $error("fault cleared without start edge");

   a_susp_resume: assert property (
      run && state_ff == ST_SUSP && !hold |=> power_switch_gate)
      else $error("no resume after suspend");

   c_charge_done: cover property (state_ff == ST_OFF ##1 state_ff == ST_DONE);
   c_short_fault: cover property ($rose(short_ff));
   c_suspend_resume: cover property (state_ff == ST_SUSP ##1 state_ff == ST_ON);
   c_maxon_fault: cover property ($rose(maxon_ff));

endmodule // fcs_charge_seq
`default_nettype wire

// File: verification/fcs_partner.sv
`timescale 1ns/1ps
`default_nettype none

module fcs_partner
   import fcs_pkg::*;
#(
   parameter int ON_CYC = 6,
   parameter int OFF_CYC = 6
)
(
   input wire logic clk,         // Clock
   input wire logic gate,        // Power switch gate
   input wire logic [4:0] host,  // Start, full, lockout, thermal, trigger
   input wire logic short_vc,    // Sense pin stuck at ground
   input wire logic open_sw,     // Switch node open, no current
   output var fcs_pins_s pins    // Comparator and host pins
);

   // ****************************************************************
   // Primary ramp and secondary discharge timers
   // ****************************************************************
   int on_cnt = 0;
   int off_cnt = 0;

   // Count time since the gate last changed
   always_ff @(posedge clk)
   begin
      on_cnt <= gate ? on_cnt + 1 : 0;
      off_cnt <= gate ? 0 : off_cnt + 1;
   end

   // Comparators trip once the ramp or discharge has run
   always_comb
   begin
      pins.start = host[4];
      pins.full = host[3];
      pins.undervoltage_lockout = host[2];
      pins.thermal_shutdown = host[1];
      pins.flash_trigger_in = host[0];
      pins.peak = gate && !open_sw && (on_cnt >= ON_CYC);
      pins.off_det = !gate && !short_vc && (off_cnt >= OFF_CYC);
   end

endmodule // fcs_partner

`default_nettype wire

// File: verification/tb_fcs_charge_seq.sv
`timescale 1ns/1ps
`default_nettype none

module tb_fcs_charge_seq
   import fcs_pkg::*;
;
   // ****************************************************************
   // Stimulus and observation
   // ****************************************************************
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [4:0] host = 5'h00; // Start, full, lockout, thermal, trigger
   logic short_vc = 1'b0;
   logic open_sw = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat_w = 32'h00000000;
   logic [3:0] sel = 4'hF;
   fcs_pins_s pins;
   logic gate;
   logic done_n;
   logic flash;
   logic ack;
   logic [31:0] dat_r;
   logic [31:0] rd;
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   int dur;

   // Clock, 20 ns period
   initial forever #10 clk = ~clk;

   fcs_charge_seq #(.SHORT_LIMIT(4)) fcs_charge_seq_inst (
      .clk(clk), .srst(srst), .pins(pins), .power_switch_gate(gate),
      .charge_done_n(done_n), .flash_gate_out(flash), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat_w),
      .wb_sel_i(sel), .wb_dat_o(dat_r), .wb_ack_o(ack));

   fcs_partner fcs_partner_inst (
      .clk(clk), .gate(gate), .host(host), .short_vc(short_vc),
      .open_sw(open_sw), .pins(pins));

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   // Classic single cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= 4'hF;
      do
      begin
         @(posedge clk);
      end
      while (ack !== 1'b1);
      rd = dat_r;
      chk("bus ack", ack, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   // Wait for the gate level, cycles taken left in dur
   task automatic wgate(input logic v, input int lim);
      dur = 0;
      while (gate !== v && dur < lim)
      begin
         @(posedge clk);
         dur++;
      end
      chk("gate level", gate, v);
   endtask

   // Gate must stay off for k cycles
   task automatic hold_low(input string name, input int k);
      int hi;
      hi = 0;
      repeat (k)
      begin
         @(posedge clk);
         if (gate !== 1'b0) hi++;
      end
      chk(name, hi, 0);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         n_fail++;
         close_out();
      end
   end

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial
   begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      wb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl reset", rd, 32'h1);
      wb(1'b1, REG_STATUS, 32'hFF);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("status", rd, 32'h0);
      wb(1'b0, REG_COUNT, 32'h0);
      chk("count", rd, 32'h0);
      wb(1'b0, 8'h0C, 32'h0);
      chk("unmapped", rd, 32'h0);
      chk("done idle", done_n, 32'h1);
      $display("test reset done");
      // Normal cycle then full charge
      host[4] <= 1'b1;
      wgate(1'b1, 10);
      wgate(1'b0, 20);
      wgate(1'b1, 20);
      host[3] <= 1'b1;
      repeat (6) @(posedge clk);
      chk("done low", done_n, 32'h0);
      hold_low("full stop", 60);
      host[3] <= 1'b0;
      host[4] <= 1'b0;
      repeat (6) @(posedge clk);
      chk("done high", done_n, 32'h1);
      $display("test normal done");
      // Lockout then thermal suspend
      for (int i = 0; i < 2; i++)
      begin
         host[0] <= 1'b1;
         host[4] <= 1'b1;
         wgate(1'b1, 10);
         chk("flash on", flash, 32'h1);
         host[2 - i] <= 1'b1;
         repeat (6) @(posedge clk);
         chk("flash gated", flash, (i == 0) ? 32'h0 : 32'h1);
         hold_low("suspend", 40);
         wb(1'b0, REG_STATUS, 32'h0);
         chk("no latch", rd[3:2], 32'h0);
         chk("suspended", rd[7], 32'h1);
         chk("hold bit", rd[5:4], (i == 0) ? 32'h1 : 32'h2);
         host[2 - i] <= 1'b0;
         wgate(1'b1, 20);
         host[4] <= 1'b0;
         host[0] <= 1'b0;
         repeat (6) @(posedge clk);
      end
      $display("test suspend done");
      // Allow bit and start low
      host[4] <= 1'b1;
      wgate(1'b1, 10);
      wb(1'b1, REG_CTRL, 32'h0);
      hold_low("allow off", 20);
      wb(1'b1, REG_CTRL, 32'h1);
      wgate(1'b1, 10);
      host[4] <= 1'b0;
      repeat (4) @(posedge clk);
      hold_low("start low", 20);
      $display("test stop done");
      // Sense short: forced-on count, clear, fault
      short_vc <= 1'b1;
      host[4] <= 1'b1;
      wgate(1'b1, 10);
      wgate(1'b0, 20);
      wgate(1'b1, 1300);
      chk("off time", 32'(dur >= 1249 && dur <= 1253), 32'h1);
      wb(1'b0, REG_COUNT, 32'h0);
      chk("count one", rd, 32'h1);
      short_vc <= 1'b0;
      wgate(1'b0, 20);
      wgate(1'b1, 20);
      wb(1'b0, REG_COUNT, 32'h0);
      chk("count clear", rd, 32'h0);
      short_vc <= 1'b1;
      repeat (3)
      begin
         wgate(1'b0, 20);
         wgate(1'b1, 1300);
      end
      wgate(1'b0, 20);
      hold_low("short fault", 1400);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("short bit", rd[2], 32'h1);
      host[4] <= 1'b0;
      short_vc <= 1'b0;
      repeat (5) @(posedge clk);
      host[4] <= 1'b1;
      wgate(1'b1, 10);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("short clear", rd[2], 32'h0);
      host[4] <= 1'b0;
      repeat (6) @(posedge clk);
      $display("test short done");
      // Maximum on-time fault, restart blocked under lockout
      open_sw <= 1'b1;
      host[4] <= 1'b1;
      wgate(1'b1, 10);
      wgate(1'b0, 2600);
      chk("on time", 32'(dur >= 2498 && dur <= 2503), 32'h1);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("maxon bit", rd[3], 32'h1);
      host[2] <= 1'b1;
      host[4] <= 1'b0;
      repeat (5) @(posedge clk);
      host[4] <= 1'b1;
      repeat (5) @(posedge clk);
      host[2] <= 1'b0;
      open_sw <= 1'b0;
      hold_low("locked restart", 40);
      host[4] <= 1'b0;
      repeat (5) @(posedge clk);
      host[4] <= 1'b1;
      wgate(1'b1, 10);
      host[4] <= 1'b0;
      $display("test maxon done");
      close_out();
   end

endmodule // tb_fcs_charge_seq

`default_nettype wire
